// ==== verilog/sild_driver.sv ====
`timescale 1ns/1ps
module sild_driver
  import sild_pkg::*;
(
  // system
  input wire logic mclk,
  input wire logic resetn,
  // controller pins
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic latch_load,
  input wire logic output_blank,
  // outputs
  output logic serial_out,
  output logic [SILD_WIDTH-1:0] parallel_output
);

  sild_state_s st_reg;
  sild_state_s st_next;
  logic rise;
  logic [SILD_WIDTH-1:0] shift_new;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // pins cross two flops; edge detect only reads the second stage
  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = '{serial_in, shift_clk, latch_load, output_blank};
    st_next.sync2 = st_reg.sync1;
    st_next.clk_prev = st_reg.sync2.shift_clk;
    rise = st_reg.sync2.shift_clk & ~st_reg.clk_prev;
    shift_new = st_reg.shift;
    // falling edges fall through untouched
    if (rise) // [RULE3]
    begin
      shift_new = {st_reg.shift[SILD_WIDTH-2:0],
                   st_reg.sync2.serial_in}; // [RULE1] [RULE2]
    end
    st_next.shift = shift_new;
    // last stage drives the chain output [RULE11]
    st_next.sout = shift_new[SILD_WIDTH-1]; // [RULE2]
    // level-sensitive latch, transparent while load stays high
    if (st_reg.sync2.latch_load) // [RULE4] [RULE5]
    begin
      st_next.latch = shift_new;
    end
    // blank wins over latch content; one cycle settling
    if (st_reg.sync2.output_blank) // [RULE6]
    begin
      st_next.outp = '0;
    end
    else
    begin
      st_next.outp = st_next.latch; // [RULE7] [RULE12]
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      st_reg <= '0;
      st_reg.shift <= SILD_RST_VEC;
      st_reg.latch <= SILD_RST_VEC;
      st_reg.outp <= SILD_RST_VEC;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign serial_out = st_reg.sout;
  assign parallel_output = st_reg.outp;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_capture;
    @(posedge mclk) disable iff (!resetn)
    (st_reg.sync2.shift_clk && !st_reg.clk_prev)
      |=> st_reg.shift[0] == $past(st_reg.sync2.serial_in);
  endproperty
  a_capture: assert property (p_capture) // [RULE1]
    else $error("serial_in not captured on rising edge");

  property p_shift;
    @(posedge mclk) disable iff (!resetn)
    (st_reg.sync2.shift_clk && !st_reg.clk_prev)
      |=> st_reg.shift[SILD_WIDTH-1:1]
          == $past(st_reg.shift[SILD_WIDTH-2:0]);
  endproperty
  a_shift: assert property (p_shift) // [RULE2]
    else $error("shift register did not move one stage");

  property p_hold;
    @(posedge mclk) disable iff (!resetn)
    !(st_reg.sync2.shift_clk && !st_reg.clk_prev)
      |=> $stable(st_reg.shift);
  endproperty
  a_hold: assert property (p_hold) // [RULE3]
    else $error("shift register changed without rising edge");

  property p_sout;
    @(posedge mclk) disable iff (!resetn)
    ##1 serial_out == st_reg.shift[SILD_WIDTH-1];
  endproperty
  a_sout: assert property (p_sout) // [RULE11]
    else $error("serial_out differs from last stage");

  property p_latch_hold;
    @(posedge mclk) disable iff (!resetn)
    !st_reg.sync2.latch_load |=> $stable(st_reg.latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE4]
    else $error("latch changed while load low");

  property p_transparent;
    @(posedge mclk) disable iff (!resetn)
    st_reg.sync2.latch_load |=> st_reg.latch == st_reg.shift;
  endproperty
  a_transparent: assert property (p_transparent) // [RULE5]
    else $error("latch not tracking shift register");

  property p_blank;
    @(posedge mclk) disable iff (!resetn)
    st_reg.sync2.output_blank |=> parallel_output == '0;
  endproperty
  a_blank: assert property (p_blank) // [RULE6]
    else $error("outputs not blanked");

  property p_show;
    @(posedge mclk) disable iff (!resetn)
    !st_reg.sync2.output_blank |=> parallel_output == st_reg.latch;
  endproperty
  a_show: assert property (p_show) // [RULE7]
    else $error("outputs do not show latch");

  // ------------------------------------------------------------
  // checks on synchroniser, edge detect, chain output, latch, blanking and reset
  // ------------------------------------------------------------
  // a broken sync stage would let metastable pin values reach logic
  property p_sync_stage;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> st_reg.sync2 == $past(st_reg.sync1);
  endproperty
  a_sync_stage: assert property (p_sync_stage)
    else $error("second sync stage does not follow first");

  property p_clk_prev;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> st_reg.clk_prev == $past(st_reg.sync2.shift_clk);
  endproperty
  a_clk_prev: assert property (p_clk_prev) // [RULE3]
    else $error("edge detector history is wrong");

  // a held-high serial clock must give exactly one shift
  property p_rise_once;
    @(posedge mclk) disable iff (!resetn)
    rise |=> !rise;
  endproperty
  a_rise_once: assert property (p_rise_once) // [RULE3]
    else $error("one clock rise seen twice");

  property p_sout_last;
    @(posedge mclk) disable iff (!resetn)
    rise |=> serial_out == $past(st_reg.shift[SILD_WIDTH-2]);
  endproperty
  a_sout_last: assert property (p_sout_last) // [RULE2]
    else $error("serial_out did not take the next-to-last stage");

  property p_sout_still;
    @(posedge mclk) disable iff (!resetn)
    !rise |=> $stable(serial_out);
  endproperty
  a_sout_still: assert property (p_sout_still) // [RULE3]
    else $error("serial_out moved without a rising edge");

  // load and shift in one cycle: latch takes the freshly shifted bit
  property p_latch_new;
    @(posedge mclk) disable iff (!resetn)
    (rise && st_reg.sync2.latch_load)
      |=> st_reg.latch[0] == $past(st_reg.sync2.serial_in);
  endproperty
  a_latch_new: assert property (p_latch_new) // [RULE4]
    else $error("latch missed bit shifted in same cycle");

  // blanking only gates the outputs, the latch must survive it
  property p_blank_keep;
    @(posedge mclk) disable iff (!resetn)
    (st_reg.sync2.output_blank && !st_reg.sync2.latch_load)
      |=> $stable(st_reg.latch);
  endproperty
  a_blank_keep: assert property (p_blank_keep) // [RULE6]
    else $error("blanking disturbed latch content");

  property p_unblank;
    @(posedge mclk) disable iff (!resetn)
    $fell(st_reg.sync2.output_blank) |=> parallel_output == st_reg.latch;
  endproperty
  a_unblank: assert property (p_unblank) // [RULE7]
    else $error("outputs did not return after blanking");

  property p_out_source;
    @(posedge mclk) disable iff (!resetn)
    1'b1 |=> (parallel_output == '0) || (parallel_output == st_reg.latch);
  endproperty
  a_out_source: assert property (p_out_source) // [RULE12]
    else $error("outputs neither blank nor latch");

  // reset must leave every pin low, no stale pattern on the loads
  property p_reset_clear;
    @(posedge mclk)
    !resetn |=> (parallel_output == '0) && (serial_out == 1'b0);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("outputs not cleared by reset");

  property p_latch_load_track;
    @(posedge mclk) disable iff (!resetn)
    st_reg.sync2.latch_load |=> st_reg.latch == $past(shift_new);
  endproperty
  a_latch_load_track: assert property (p_latch_load_track) // [RULE5]
    else $error("latch did not take shift register value");

endmodule : sild_driver

// ==== verilog/sild_pkg.sv ====
// How it works
// [RULE1] rising serial clock edge captures serial_in into first shift stage
// [RULE2] each rising edge shifts toward serial_out; serial_out shows last stage
// [RULE3] falling serial clock edges leave shift register and serial_out alone
// [RULE4] latch_load high copies shift register into latch; low holds latch
// [RULE5] latch_load held high makes latch and outputs follow shift register
// [RULE6] output_blank high forces every parallel output low
// [RULE7] output_blank low: outputs show latch bits after settling delay
// [RULE8] controller keeps serial_in stable around each rising clock edge
// [RULE9] controller waits strobe setup time after last clock before loading
// [RULE10] controller should blank outputs while shifting new data in; the tests blank only the first shift of t_load
// [RULE11] serial_out can feed the serial_in of a following device in a chain
// [RULE12] sixteen parallel outputs, each with its own latch and shift stage
package sild_pkg;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int SILD_WIDTH = 16;
  localparam logic [SILD_WIDTH-1:0] SILD_RST_VEC = 16'h0000;

  // pins sampled from the controller
  typedef struct packed {
    logic serial_in;
    logic shift_clk;
    logic latch_load;
    logic output_blank;
  } sild_pins_s;

  // whole module state
  typedef struct packed {
    sild_pins_s sync1;
    sild_pins_s sync2;
    logic clk_prev;
    logic [SILD_WIDTH-1:0] shift;
    logic [SILD_WIDTH-1:0] latch;
    logic [SILD_WIDTH-1:0] outp;
    logic sout;
  } sild_state_s;

endpackage : sild_pkg

// ==== test/sild_ctrl_model.sv ====
`timescale 1ns/1ps
module sild_ctrl_model
  import sild_pkg::*;
(
  // clock
  input wire logic mclk,
  // controller pins
  output logic serial_in,
  output logic shift_clk,
  output logic latch_load,
  output logic output_blank
);
  // -----------------------------------------
  // controller behaviour
  // -----------------------------------------
  initial {serial_in, shift_clk, latch_load, output_blank} = 4'h0;
  // msb first; data flips at the falling edge so a bad capture shows
  task shift_word(input logic [SILD_WIDTH-1:0] w);
    for (int i = SILD_WIDTH - 1; i >= 0; i--)
    begin
      serial_in <= w[i];
      repeat (3) @(posedge mclk);
      shift_clk <= 1'b1;
      repeat (3) @(posedge mclk);
      shift_clk <= 1'b0;
      serial_in <= ~w[i];
      repeat (3) @(posedge mclk);
    end
  endtask : shift_word
  // setup of 300 ns and pulse of 100 ns at 50 ns per cycle
  task strobe();
    repeat (6) @(posedge mclk);
    latch_load <= 1'b1;
    repeat (2) @(posedge mclk);
    latch_load <= 1'b0;
  endtask : strobe
  task set_pins(input logic load, input logic blank);
    // pins only move on a clock edge, even when called mid-cycle
    @(posedge mclk);
    latch_load <= load;
    output_blank <= blank;
  endtask : set_pins
endmodule : sild_ctrl_model

// ==== test/test_serial_in_latched_output_driver.sv ====
`timescale 1ns/1ps
module test_serial_in_latched_output_driver;
  import sild_pkg::*;
  logic mclk, resetn, serial_in, shift_clk, latch_load, output_blank;
  logic serial_out;
  logic [SILD_WIDTH-1:0] parallel_output;
  int n_errors = 0;
  int num_checks = 0;
  // 50 ns clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  sild_driver i_sild_driver (.mclk(mclk), .resetn(resetn),
    .serial_in(serial_in), .shift_clk(shift_clk), .latch_load(latch_load),
    .output_blank(output_blank), .serial_out(serial_out),
    .parallel_output(parallel_output));
  sild_ctrl_model i_sild_ctrl_model (.mclk(mclk), .serial_in(serial_in),
    .shift_clk(shift_clk), .latch_load(latch_load),
    .output_blank(output_blank));
  // -----------------------------------------
  // checks and scenarios
  // -----------------------------------------
  task check(input string what, input logic [SILD_WIDTH-1:0] exp, got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // shift while blanked, load, unblank, then shift again with latch held
  task t_load;
    i_sild_ctrl_model.set_pins(1'b0, 1'b1);
    i_sild_ctrl_model.shift_word(16'ha5c3);
    i_sild_ctrl_model.strobe();
    repeat (6) @(posedge mclk);
    #1 check("blanked", 16'h0000, parallel_output);
    i_sild_ctrl_model.set_pins(1'b0, 1'b0);
    repeat (6) @(posedge mclk);
    #1 check("loaded", 16'ha5c3, parallel_output);
    check("sout_hi", 16'h0001, {15'h0000, serial_out});
    i_sild_ctrl_model.shift_word(16'h0f0f);
    #1 check("held", 16'ha5c3, parallel_output);
    check("sout_lo", 16'h0000, {15'h0000, serial_out});
    $display("t_load done");
  endtask : t_load
  // strobe held high: outputs follow the shift register
  task t_transparent;
    i_sild_ctrl_model.set_pins(1'b1, 1'b0);
    i_sild_ctrl_model.shift_word(16'h8001);
    repeat (6) @(posedge mclk);
    #1 check("transparent", 16'h8001, parallel_output);
    $display("t_transparent done");
  endtask : t_transparent
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  // main sequence after 8 cycles of reset
  initial
  begin
    resetn = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    t_load();
    t_transparent();
    report_and_stop();
  end
  // about 470 cycles expected; cut a hang well beyond that
  initial
  begin
    repeat (5000) @(posedge mclk);
    n_errors++;
    report_and_stop();
  end
endmodule : test_serial_in_latched_output_driver
